/* File: pkg/tlf_pkg.sv */
package tlf_pkg;

  // Command codes on the management port
  localparam logic [7:0] CODE_OT_WARN = 8'h51;
  localparam logic [7:0] CODE_UT_WARN = 8'h52;
  localparam logic [7:0] CODE_UT_FAULT = 8'h53;
  localparam logic [7:0] CODE_UT_RESP = 8'h54;
  localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;

  // Reset values
  localparam logic [15:0] RST_OT_WARN = 16'h0000;
  localparam logic [15:0] RST_UT_WARN = 16'h0000;
  localparam logic [15:0] RST_UT_FAULT = 16'h0000;
  localparam logic [7:0] RST_UT_RESP = 8'h00;

  // Field positions of the response byte
  localparam int RESP_ACT_MSB = 7;
  localparam int RESP_ACT_LSB = 6;
  localparam int RESP_TRY_MSB = 5;
  localparam int RESP_TRY_LSB = 3;
  localparam int RESP_DLY_MSB = 2;
  localparam int RESP_DLY_LSB = 0;

  // Response actions
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_GRACE = 2'h1;
  localparam logic [1:0] ACT_DISABLE = 2'h2;
  localparam logic [1:0] ACT_LATCH = 2'h3;

  // Retry settings
  localparam logic [2:0] TRY_NONE = 3'h0;
  localparam logic [2:0] TRY_FOREVER = 3'h7;

  // Linear format: 5-bit signed exponent, 11-bit signed mantissa
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_FRAC_BITS = 16;

  typedef struct packed {
    logic [1:0] action;
    logic [2:0] retries;
    logic [2:0] delayExp;
  } tlf_resp_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } tlf_cmd_s;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_GRACE = 3'b001,
    ST_HOLDOFF = 3'b010,
    ST_RETRY = 3'b011,
    ST_LATCH = 3'b100
  } tlf_state_e;

  // Linear value to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] tlf_lin2fix(input logic [15:0] lin);
    logic signed [4:0] e;
    logic signed [47:0] m;
    logic [5:0] sh;
    e = lin[15:LIN_EXP_LSB];
    m = 48'(signed'(lin[LIN_EXP_LSB-1:0]));
    sh = 6'(int'(e) + LIN_FRAC_BITS);
    return m <<< sh;
  endfunction

endpackage

/* File: rtl/tlf_delay_timer.sv */
`timescale 1ns/10ps
module tlf_delay_timer
  import tlf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2:0] delayExp,
  input wire logic [15:0] unitCycles,
  output logic done
);

  logic run_r;
  logic [15:0] per_r;
  logic [15:0] div_r;
  logic [8:0] left_r;
  logic [8:0] units_r;
  logic [24:0] elapsed_r;

  // Done is combinational so the next interval can start on the very edge that ends this one
  assign done = run_r & (div_r == per_r - 16'h0001) & (left_r == 9'h001);

  // Unit length is sampled at start; a zero unit is taken as one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      per_r <= 16'h0001;
      div_r <= 16'h0000;
      left_r <= 9'h000;
      units_r <= 9'h000;
    end else begin
      if (start) begin
        run_r <= 1'b1;
        per_r <= (unitCycles == 16'h0000) ? 16'h0001 : unitCycles;
        div_r <= 16'h0000;
        left_r <= 9'h001 << delayExp;
        units_r <= 9'h001 << delayExp;
      end else if (run_r) begin
        if (div_r == per_r - 16'h0001) begin
          div_r <= 16'h0000;
          if (left_r == 9'h001) begin
            run_r <= 1'b0;
          end else begin
            left_r <= left_r - 9'h001;
          end
        end else begin
          div_r <= div_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_r <= 25'h000_0000;
    end else if (start) begin
      elapsed_r <= 25'h000_0000;
    end else if (run_r) begin
      elapsed_r <= elapsed_r + 25'h000_0001;
    end
  end

  property p_span;
    @(posedge mclk) disable iff (!rst_n)
    done |-> elapsed_r == 25'(per_r) * 25'(units_r) - 25'h000_0001;
  endproperty
  a_span: assert property (p_span) else $error("delay span wrong");

endmodule

/* File: rtl/tlf_temp_supervisor.sv */
`timescale 1ns/10ps
// What this block does
// - Holds a 16-bit Linear over-temperature warning limit, host read and write.
// - Holds a 16-bit Linear under-temperature warning limit, host read and write.
// - Holds a 16-bit Linear under-temperature fault limit, host read and write.
// - Action 00 ignores the fault; output keeps running.
// - Action 01 runs on for the delay, then follows the retry setting if fault persists.
// - Action 10 disables output at once, then follows the retry setting.
// - Action 11 holds output off until bit clear, clear command, reset or off-on.
// - Retry setting 000 never restarts; output stays off until cleared.
// - Retry settings 1 to 6 allow that many attempts, then latch off.
// - Attempt starts are spaced by two to the delay field times the unit.
// - Retry setting 111 retries until commanded off or another fault stops it.
// - Delay field n selects two to the n time units.
// - Time unit length comes from the separate unit configuration.
module tlf_temp_supervisor
  import tlf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire tlf_cmd_s cmd,
  output logic [15:0] cmdRdData,
  output logic cmdRdValid,
  output logic cmdBad,
  input wire logic tempValid,
  input wire logic [15:0] tempMeas,
  input wire logic [15:0] unitCycles,
  input wire logic faultBitClr,
  input wire logic onCommand,
  input wire logic otherShutdown,
  output logic outputEnable,
  output logic otWarn,
  output logic utWarn,
  output logic utFaultNow,
  output logic utFaultFlag
);

  logic [15:0] otWarnLim_r;
  logic [15:0] utWarnLim_r;
  logic [15:0] utFaultLim_r;
  tlf_resp_s resp_r;
  tlf_state_e state_r;
  logic [2:0] tries_r;
  logic timerStart_r;
  logic timerStart;
  logic timerDone;
  logic faultRise;
  logic clearCmd;
  logic clearAny;
  logic stopped;
  logic wrHit;
  logic rdHit;
  logic signed [47:0] tempFix;

  assign wrHit = cmd.valid & cmd.write;
  assign rdHit = cmd.valid & ~cmd.write;
  assign clearCmd = wrHit & (cmd.code == CODE_CLEAR_FAULTS);
  assign clearAny = clearCmd | faultBitClr;
  // Commanded off or shut down by another fault ends any sequence except a latch
  assign stopped = ~onCommand | otherShutdown;
  assign tempFix = tlf_lin2fix(tempMeas);

  // Limit and response storage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      otWarnLim_r <= RST_OT_WARN;
      utWarnLim_r <= RST_UT_WARN;
      utFaultLim_r <= RST_UT_FAULT;
      resp_r <= RST_UT_RESP;
    end else if (wrHit) begin
      case (cmd.code)
        CODE_OT_WARN: begin
          otWarnLim_r <= cmd.data;
        end
        CODE_UT_WARN: begin
          utWarnLim_r <= cmd.data;
        end
        CODE_UT_FAULT: begin
          utFaultLim_r <= cmd.data;
        end
        CODE_UT_RESP: begin
          resp_r <= cmd.data[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read-back; unknown codes answer zero with cmdBad
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmdRdData <= 16'h0000;
      cmdRdValid <= 1'b0;
      cmdBad <= 1'b0;
    end else begin
      cmdRdValid <= rdHit;
      cmdBad <= 1'b0;
      if (rdHit) begin
        case (cmd.code)
          CODE_OT_WARN: begin
            cmdRdData <= otWarnLim_r;
          end
          CODE_UT_WARN: begin
            cmdRdData <= utWarnLim_r;
          end
          CODE_UT_FAULT: begin
            cmdRdData <= utFaultLim_r;
          end
          CODE_UT_RESP: begin
            cmdRdData <= {8'h00, resp_r};
          end
          default: begin
            cmdRdData <= 16'h0000;
            cmdBad <= 1'b1;
          end
        endcase
      end else if (wrHit) begin
        case (cmd.code)
          CODE_OT_WARN, CODE_UT_WARN, CODE_UT_FAULT, CODE_UT_RESP,
          CODE_CLEAR_FAULTS: begin
            cmdBad <= 1'b0;
          end
          default: begin
            cmdBad <= 1'b1;
          end
        endcase
      end
    end
  end

  // Comparisons happen only on a fresh measurement, so levels hold between samples
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      otWarn <= 1'b0;
      utWarn <= 1'b0;
      utFaultNow <= 1'b0;
    end else if (tempValid) begin
      otWarn <= tempFix > tlf_lin2fix(otWarnLim_r);
      utWarn <= tempFix < tlf_lin2fix(utWarnLim_r);
      utFaultNow <= tempFix < tlf_lin2fix(utFaultLim_r);
    end
  end

  assign faultRise = tempValid & ~utFaultNow & (tempFix < tlf_lin2fix(utFaultLim_r));

  // Sticky status; a new fault in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      utFaultFlag <= 1'b0;
    end else if (faultRise) begin
      utFaultFlag <= 1'b1;
    end else if (clearAny) begin
      utFaultFlag <= 1'b0;
    end
  end

  // Timer starts on the edge of the state change, so attempt starts sit exactly one delay apart;
  // timerStart_r is only its registered echo for the checks
  always_comb begin
    timerStart = 1'b0;
    if (!(stopped && state_r != ST_LATCH)) begin
      case (state_r)
        ST_RUN: begin
          timerStart = faultRise && (resp_r.action == ACT_GRACE
            || (resp_r.action == ACT_DISABLE && resp_r.retries != TRY_NONE));
        end
        ST_GRACE: begin
          timerStart = timerDone && utFaultNow && (resp_r.retries != TRY_NONE);
        end
        ST_HOLDOFF: begin
          timerStart = timerDone;
        end
        ST_RETRY: begin
          timerStart = timerDone && utFaultNow
            && (resp_r.retries == TRY_FOREVER || tries_r < resp_r.retries);
        end
        default: begin
          timerStart = 1'b0;
        end
      endcase
    end
  end

  // Fault response sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      tries_r <= 3'h0;
      timerStart_r <= 1'b0;
    end else begin
      timerStart_r <= 1'b0;
      if (stopped && state_r != ST_LATCH) begin
        state_r <= ST_RUN;
        tries_r <= 3'h0;
      end else begin
        case (state_r)
          ST_RUN: begin
            if (faultRise) begin
              case (resp_r.action)
                ACT_IGNORE: begin
                  state_r <= ST_RUN;
                end
                ACT_GRACE: begin
                  state_r <= ST_GRACE;
                  timerStart_r <= 1'b1;
                end
                ACT_DISABLE: begin
                  tries_r <= 3'h0;
                  if (resp_r.retries == TRY_NONE) begin
                    state_r <= ST_LATCH;
                  end else begin
                    state_r <= ST_HOLDOFF;
                    timerStart_r <= 1'b1;
                  end
                end
                default: begin
                  state_r <= ST_LATCH;
                end
              endcase
            end
          end
          ST_GRACE: begin
            if (timerDone) begin
              tries_r <= 3'h0;
              if (!utFaultNow) begin
                state_r <= ST_RUN;
              end else if (resp_r.retries == TRY_NONE) begin
                state_r <= ST_LATCH;
              end else begin
                state_r <= ST_HOLDOFF;
                timerStart_r <= 1'b1;
              end
            end
          end
          ST_HOLDOFF: begin
            if (timerDone) begin
              state_r <= ST_RETRY;
              tries_r <= 3'h1;
              timerStart_r <= 1'b1;
            end
          end
          ST_RETRY: begin
            if (timerDone) begin
              if (!utFaultNow) begin
                state_r <= ST_RUN;
                tries_r <= 3'h0;
              end else if (resp_r.retries == TRY_FOREVER) begin
                timerStart_r <= 1'b1;
              end else if (tries_r < resp_r.retries) begin
                tries_r <= tries_r + 3'h1;
                timerStart_r <= 1'b1;
              end else begin
                state_r <= ST_LATCH;
              end
            end
          end
          ST_LATCH: begin
            // Commanded off also releases; a shutdown by another fault alone does not
            if (clearAny || !onCommand) begin
              state_r <= ST_RUN;
              tries_r <= 3'h0;
            end
          end
          default: begin
            state_r <= ST_RUN;
          end
        endcase
      end
    end
  end

  // Output is off in hold-off and latch; restart attempts switch it back on
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outputEnable <= 1'b0;
    end else begin
      outputEnable <= ~stopped & (state_r != ST_HOLDOFF) & (state_r != ST_LATCH);
    end
  end

  tlf_delay_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(timerStart),
    .delayExp(resp_r.delayExp),
    .unitCycles(unitCycles),
    .done(timerDone)
  );

  property p_ignore;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == ST_RUN && faultRise && resp_r.action == ACT_IGNORE && !stopped)
      |=> state_r == ST_RUN ##1 outputEnable;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore left run");

  property p_grace;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == ST_RUN && faultRise && resp_r.action == ACT_GRACE && !stopped)
      |=> state_r == ST_GRACE && timerStart_r ##1 outputEnable;
  endproperty
  a_grace: assert property (p_grace) else $error("grace not entered");

  property p_disable;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == ST_RUN && faultRise && resp_r.action == ACT_DISABLE && !stopped
      && resp_r.retries != TRY_NONE) |=> state_r == ST_HOLDOFF ##1 !outputEnable;
  endproperty
  a_disable: assert property (p_disable) else $error("output not disabled");

  property p_latch_hold;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == ST_LATCH && !clearAny && onCommand) |=> state_r == ST_LATCH && !outputEnable;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released");

  property p_no_retry;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == ST_RUN && faultRise && resp_r.action == ACT_DISABLE && !stopped
      && resp_r.retries == TRY_NONE) |=> state_r == ST_LATCH;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart with zero retries");

  property p_give_up;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == ST_RETRY && timerDone && utFaultNow && !stopped
      && resp_r.retries != TRY_FOREVER && tries_r >= resp_r.retries) |=> state_r == ST_LATCH;
  endproperty
  a_give_up: assert property (p_give_up) else $error("retries not exhausted");

  property p_forever;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == ST_RETRY && timerDone && utFaultNow && !stopped
      && resp_r.retries == TRY_FOREVER) |=> state_r == ST_RETRY && timerStart_r;
  endproperty
  a_forever: assert property (p_forever) else $error("endless retry stopped");

  property p_flag;
    @(posedge mclk) disable iff (!rst_n)
    faultRise |=> utFaultFlag && utFaultNow;
  endproperty
  a_flag: assert property (p_flag) else $error("fault flag missed");

  property p_readback;
    @(posedge mclk) disable iff (!rst_n)
    (rdHit && cmd.code == CODE_OT_WARN) |=> cmdRdValid && cmdRdData == $past(otWarnLim_r);
  endproperty
  a_readback: assert property (p_readback) else $error("limit read-back wrong");

  property p_start_echo;
    @(posedge mclk) disable iff (!rst_n)
    timerStart_r == $past(timerStart);
  endproperty
  a_start_echo: assert property (p_start_echo) else $error("timer start decode differs");

endmodule

/* File: verification/tlf_host_model.sv */
`timescale 1ns/10ps
module tlf_host_model
  import tlf_pkg::*;
(
  input wire logic mclk,
  output tlf_cmd_s cmd
);
  initial cmd = '0;

  // One command per call, valid for one edge; released fields show the inverse, never stale data
  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk) #1;
    cmd <= '{valid: 1'b1, write: wr, code: code, data: data};
    @(posedge mclk) #1;
    cmd <= '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
  endtask
endmodule

/* File: verification/tlf_temp_supervisor_test.sv */
`timescale 1ns/10ps
module tlf_temp_supervisor_test
  import tlf_pkg::*;
;
  // Unit of 3 cycles and delay field 2 give 12 cycles
  localparam int SPAN = 12;
  localparam logic [15:0] T_OK = 16'h0819;
  localparam logic [15:0] T_LOW = 16'h07fd;
  logic mclk, rst_n, tempValid, faultBitClr, onCommand, otherShutdown;
  logic cmdRdValid, cmdBad, outputEnable, otWarn, utWarn, utFaultNow, utFaultFlag;
  logic [15:0] tempMeas, unitCycles, cmdRdData;
  logic [15:0] v;
  logic [15:0] expQ[$];
  tlf_cmd_s cmd;
  int numErrors = 0;
  int totalChecks = 0;
  int badCnt = 0;
  int cycles = 0;
  int seed = 32'h0000_aeba;
  int n;

  tlf_temp_supervisor uut (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .cmdRdData(cmdRdData),
    .cmdRdValid(cmdRdValid), .cmdBad(cmdBad), .tempValid(tempValid), .tempMeas(tempMeas),
    .unitCycles(unitCycles), .faultBitClr(faultBitClr), .onCommand(onCommand),
    .otherShutdown(otherShutdown), .outputEnable(outputEnable), .otWarn(otWarn),
    .utWarn(utWarn), .utFaultNow(utFaultNow), .utFaultFlag(utFaultFlag));
  tlf_host_model host (.mclk(mclk), .cmd(cmd));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic fail(input string msg);
    numErrors++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    totalChecks++;
    if (got !== exp) fail($sformatf("%s is %b", what, got));
  endtask

  task automatic chkn(input int got, input int exp, input string what);
    totalChecks++;
    if (got != exp) fail($sformatf("%s %0d expected %0d", what, got, exp));
  endtask

  task automatic giveVerdict();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    host.send(1'b1, code, data);
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    expQ.push_back(exp);
    host.send(1'b0, code, 16'($random(seed)));
  endtask

  task automatic temp(input logic [15:0] t);
    @(posedge mclk) #1;
    tempMeas <= t;
    tempValid <= 1'b1;
    @(posedge mclk) #1;
    tempValid <= 1'b0;
  endtask

  task automatic runLen(input logic lvl, output int len);
    len = 0;
    while (outputEnable === lvl && len < 2000) begin
      @(posedge mclk) #1;
      len++;
    end
  endtask

  task automatic hiCnt(input int len, output int h);
    h = 0;
    repeat (len) begin
      @(posedge mclk) #1;
      if (outputEnable === 1'b1) h++;
    end
  endtask

  // Each fault case starts from a cleared latch and a fresh falling temperature
  task automatic trip(input logic [7:0] resp);
    wr(CODE_CLEAR_FAULTS, 16'h0000);
    repeat (3) @(posedge mclk);
    #1 chkb(outputEnable, 1'b1, "output after clear");
    wr(CODE_UT_RESP, {8'h00, resp});
    temp(T_OK);
    temp(T_LOW);
  endtask

  always @(posedge mclk) begin
    if (cmdBad === 1'b1) badCnt++;
    if (cmdRdValid === 1'b1) begin
      if (expQ.size() == 0) fail("read data without a request");
      else chk16(cmdRdData, expQ.pop_front());
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail("timeout");
      giveVerdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    tempValid = 1'b0;
    tempMeas = T_OK;
    unitCycles = 16'h0003;
    faultBitClr = 1'b0;
    onCommand = 1'b1;
    otherShutdown = 1'b0;
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(8'h51 + i), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      v = 16'($random(seed));
      wr(8'(8'h51 + i), v);
      rd(8'(8'h51 + i), v);
    end
    v = 16'($random(seed));
    wr(CODE_UT_RESP, v);
    rd(CODE_UT_RESP, {8'h00, v[7:0]});
    wr(8'h99, 16'h1234);
    rd(8'h99, 16'h0000);
    repeat (2) @(posedge mclk);
    chkn(badCnt, 2, "unknown code strobes");
    wr(CODE_UT_RESP, 16'h0000);
    wr(CODE_OT_WARN, 16'h001e);
    wr(CODE_UT_WARN, 16'h000a);
    wr(CODE_UT_FAULT, 16'h0014);
    temp(T_OK);
    chkb(otWarn, 1'b1, "over warning");
    chkb(utWarn, 1'b0, "under warning");
    temp(16'h000f);
    chkb(otWarn, 1'b0, "over warning");
    chkb(utWarn, 1'b0, "under warning");
    chkb(utFaultNow, 1'b1, "under fault");
    temp(T_OK);
    temp(T_LOW);
    chkb(utWarn, 1'b1, "under warning");
    hiCnt(4 * SPAN, n);
    chkn(n, 4 * SPAN, "on cycles while ignoring");
    trip({ACT_DISABLE, 3'd0, 3'd2});
    @(posedge mclk) #1;
    chkb(outputEnable, 1'b0, "output on fault");
    hiCnt(3 * SPAN, n);
    chkn(n, 0, "restarts without retries");
    chkb(utFaultFlag, 1'b1, "fault flag");
    trip({ACT_DISABLE, 3'd1, 3'd2});
    @(posedge mclk) #1;
    runLen(1'b0, n);
    chkb(n >= SPAN && n <= SPAN + 1, 1'b1, "off span");
    runLen(1'b1, n);
    chkb(n >= SPAN && n <= SPAN + 1, 1'b1, "attempt span");
    hiCnt(3 * SPAN, n);
    chkn(n, 0, "restarts after last attempt");
    trip({ACT_GRACE, 3'd0, 3'd2});
    runLen(1'b1, n);
    chkb(n >= SPAN && n <= SPAN + 2, 1'b1, "run on span");
    hiCnt(3 * SPAN, n);
    chkn(n, 0, "restarts after run on");
    trip({ACT_LATCH, 3'd7, 3'd0});
    hiCnt(3 * SPAN, n);
    chkn(n, 0, "on cycles while latched");
    faultBitClr = 1'b1;
    @(posedge mclk) #1;
    faultBitClr = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chkb(outputEnable, 1'b1, "output after bit clear");
    trip({ACT_DISABLE, 3'd7, 3'd2});
    hiCnt(8 * SPAN, n);
    chkb(n > 0, 1'b1, "endless restarts");
    onCommand = 1'b0;
    repeat (3) @(posedge mclk);
    hiCnt(2 * SPAN, n);
    chkn(n, 0, "restarts after off command");
    onCommand = 1'b1;
    repeat (3) @(posedge mclk);
    #1 chkb(outputEnable, 1'b1, "output after off then on");
    trip({ACT_DISABLE, 3'd7, 3'd2});
    hiCnt(4 * SPAN, n);
    otherShutdown = 1'b1;
    repeat (3) @(posedge mclk);
    hiCnt(2 * SPAN, n);
    chkn(n, 0, "restarts after shutdown");
    otherShutdown = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chkb(outputEnable, 1'b1, "output after shutdown ends");
    trip({ACT_LATCH, 3'd0, 3'd0});
    otherShutdown = 1'b1;
    repeat (3) @(posedge mclk);
    #1 otherShutdown = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chkb(outputEnable, 1'b0, "latch after shutdown");
    chkb(utFaultFlag, 1'b1, "fault flag while latched");
    wr(CODE_CLEAR_FAULTS, 16'h0000);
    chkb(utFaultFlag, 1'b0, "fault flag after clear");
    repeat (3) @(posedge mclk);
    #1 chkb(outputEnable, 1'b1, "output after clear command");
    repeat (5) @(posedge mclk);
    chkn(expQ.size(), 0, "reads left unanswered");
    giveVerdict();
  end
endmodule
